// file: bclr_pkg.sv
package bclr_pkg;

  // link request kinds, one per bus condition or byte
  typedef enum logic [2:0] {
    BCLR_K_START = 3'h0,
    BCLR_K_STOP  = 3'h1,
    BCLR_K_WRITE = 3'h2,
    BCLR_K_READ  = 3'h3,
    BCLR_K_RACK  = 3'h4
  } bclr_kind_e;

  // host operations
  typedef enum logic [1:0] {
    BCLR_OP_WRITE_CONFIG_CMD       = 2'h0,
    BCLR_OP_LRST_POLL  = 2'h1,
    BCLR_OP_LRST_PLAIN = 2'h2,
    BCLR_OP_SETPTR     = 2'h3
  } bclr_op_e;

  // device address and command codes: arbitrary values
  localparam logic [6:0] BCLR_DEV_ADDR              = 7'h18;
  localparam logic [7:0] BCLR_WRITE_CONFIG_CMD      = 8'hD2;
  localparam logic [7:0] BCLR_LINE_RESET_CMD        = 8'hB4;
  localparam logic [7:0] BCLR_SET_READ_POINTER_CMD  = 8'hE1;

  localparam logic [7:0] BCLR_PTR_CONFIG            = 8'hC3;
  localparam logic [7:0] BCLR_PTR_INVALID           = 8'hE5;

  localparam logic [7:0] BCLR_CFG_RESET             = 8'h00;
  localparam logic [7:0] BCLR_IDLE_READ             = 8'hFF;
  localparam int         BCLR_STAT_BUSY_BIT         = 0;
  localparam int         BCLR_STAT_PRES_BIT         = 1;

  // timing
  localparam int         BCLR_CLK_PERIOD_NS         = 20;
  localparam int         BCLR_LINE_RESET_NS         = 2000;
  localparam logic [7:0] BCLR_LINE_RESET_CYC        =
    8'((BCLR_LINE_RESET_NS + BCLR_CLK_PERIOD_NS - 1) / BCLR_CLK_PERIOD_NS);
  localparam logic [7:0] BCLR_HOST_MARGIN_CYC       = 8'h04;
  localparam logic [7:0] BCLR_HOST_WAIT_CYC         = 8'(BCLR_LINE_RESET_CYC + BCLR_HOST_MARGIN_CYC);

  typedef enum logic [2:0] {
    BCLR_D_IDLE   = 3'h0,
    BCLR_D_ADDR   = 3'h1,
    BCLR_D_CMD    = 3'h3,
    BCLR_D_CFG    = 3'h2,
    BCLR_D_PTR    = 3'h6,
    BCLR_D_READ   = 3'h7,
    BCLR_D_IGNORE = 3'h5
  } bclr_dst_e;

  typedef enum logic [3:0] {
    BCLR_H_IDLE  = 4'h0,
    BCLR_H_START = 4'h1,
    BCLR_H_ADDRW = 4'h3,
    BCLR_H_CMD   = 4'h2,
    BCLR_H_ARG   = 4'h6,
    BCLR_H_SR    = 4'h7,
    BCLR_H_ADDRR = 4'h5,
    BCLR_H_READ  = 4'h4,
    BCLR_H_RACK  = 4'hC,
    BCLR_H_STOP  = 4'hD,
    BCLR_H_WAIT  = 4'hF
  } bclr_hst_e;

endpackage

// file: bclr_link_if.sv
`timescale 1ns/1ps
interface bclr_link_if;
  import bclr_pkg::*;
  logic             h_valid;
  bclr_kind_e       h_kind;
  logic [7:0]       h_data;
  logic             d_done;
  logic             d_ack;
  logic [7:0]       d_data;

  modport dev  (input h_valid, h_kind, h_data, output d_done, d_ack, d_data);
  modport host (output h_valid, h_kind, h_data, input d_done, d_ack, d_data);
endinterface

// file: bclr_host.sv
`timescale 1ns/1ps
module bclr_host (
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  bclr_link_if.host              link,
  input  wire logic              go_i,
  input  wire bclr_pkg::bclr_op_e op_i,
  input  wire logic [7:0]        arg_i,
  input  wire logic              verify_i,
  output logic                   done_o,
  output logic                   refused_o,
  output logic [7:0]             rd_data_o,
  output logic                   busy_o
);
  import bclr_pkg::*;

  typedef struct packed {
    bclr_hst_e  st;
    logic       pend;
    bclr_kind_e kind;
    logic [7:0] data;
    bclr_op_e   op;
    logic [7:0] arg;
    logic       verify;
    logic       wait_flag;
    logic       cont;
    logic [7:0] cnt;
    logic       refused;
    logic [7:0] rdata;
    logic       done;
  } bclr_hstate_s;

  bclr_hstate_s s_r;
  bclr_hstate_s s_nxt;

  assign link.h_valid = s_r.pend;
  assign link.h_kind  = s_r.kind;
  assign link.h_data  = s_r.data;
  assign done_o       = s_r.done;
  assign refused_o    = s_r.refused;
  assign rd_data_o    = s_r.rdata;
  assign busy_o       = (s_r.st != BCLR_H_IDLE);

  function automatic bclr_hstate_s issue(bclr_hstate_s s, bclr_kind_e k, logic [7:0] d, bclr_hst_e n);
    bclr_hstate_s o;
    o      = s;
    o.pend = 1'b1;
    o.kind = k;
    o.data = d;
    o.st   = n;
    return o;
  endfunction

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (s_r.pend && link.d_done) begin
      s_nxt.pend = 1'b0;
      case (s_r.st)
        BCLR_H_START: begin
          s_nxt = issue(s_nxt, BCLR_K_WRITE, {BCLR_DEV_ADDR, 1'b0}, BCLR_H_ADDRW);
        end
        BCLR_H_ADDRW: begin
          if (!link.d_ack) begin
            s_nxt.refused   = 1'b1;
            s_nxt.wait_flag = 1'b0;
            s_nxt = issue(s_nxt, BCLR_K_STOP, 8'h00, BCLR_H_STOP);
          end else if (s_r.op == BCLR_OP_WRITE_CONFIG_CMD) begin
            s_nxt = issue(s_nxt, BCLR_K_WRITE, BCLR_WRITE_CONFIG_CMD, BCLR_H_CMD);
          end else if (s_r.op == BCLR_OP_SETPTR) begin
            s_nxt = issue(s_nxt, BCLR_K_WRITE, BCLR_SET_READ_POINTER_CMD, BCLR_H_CMD);
          end else begin
            s_nxt = issue(s_nxt, BCLR_K_WRITE, BCLR_LINE_RESET_CMD, BCLR_H_CMD);
          end
        end
        BCLR_H_CMD: begin
          if (!link.d_ack) begin
            // refused command code: stop at once, caller retries later
            s_nxt.refused   = 1'b1;
            s_nxt.wait_flag = 1'b0;
            s_nxt = issue(s_nxt, BCLR_K_STOP, 8'h00, BCLR_H_STOP);
          end else if (s_r.op == BCLR_OP_LRST_POLL) begin
            s_nxt = issue(s_nxt, BCLR_K_START, 8'h00, BCLR_H_SR);
          end else if (s_r.op == BCLR_OP_LRST_PLAIN) begin
            s_nxt.wait_flag = 1'b1;
            s_nxt = issue(s_nxt, BCLR_K_STOP, 8'h00, BCLR_H_STOP);
          end else begin
            s_nxt = issue(s_nxt, BCLR_K_WRITE, s_r.arg, BCLR_H_ARG);
          end
        end
        BCLR_H_ARG: begin
          if (!link.d_ack) begin
            s_nxt.refused = 1'b1;
            s_nxt = issue(s_nxt, BCLR_K_STOP, 8'h00, BCLR_H_STOP);
          end else if (s_r.verify && s_r.op == BCLR_OP_WRITE_CONFIG_CMD) begin
            s_nxt = issue(s_nxt, BCLR_K_START, 8'h00, BCLR_H_SR);
          end else begin
            s_nxt = issue(s_nxt, BCLR_K_STOP, 8'h00, BCLR_H_STOP);
          end
        end
        BCLR_H_SR: begin
          s_nxt = issue(s_nxt, BCLR_K_WRITE, {BCLR_DEV_ADDR, 1'b1}, BCLR_H_ADDRR);
        end
        BCLR_H_ADDRR: begin
          if (!link.d_ack) begin
            s_nxt.refused = 1'b1;
            s_nxt = issue(s_nxt, BCLR_K_STOP, 8'h00, BCLR_H_STOP);
          end else begin
            s_nxt = issue(s_nxt, BCLR_K_READ, 8'h00, BCLR_H_READ);
          end
        end
        BCLR_H_READ: begin
          s_nxt.rdata = link.d_data;
          // keep polling while the busy flag still reads one
          s_nxt.cont  = (s_r.op == BCLR_OP_LRST_POLL) && link.d_data[BCLR_STAT_BUSY_BIT];
          s_nxt = issue(s_nxt, BCLR_K_RACK, {7'h00, s_nxt.cont}, BCLR_H_RACK);
        end
        BCLR_H_RACK: begin
          if (s_r.cont) begin
            s_nxt = issue(s_nxt, BCLR_K_READ, 8'h00, BCLR_H_READ);
          end else begin
            s_nxt = issue(s_nxt, BCLR_K_STOP, 8'h00, BCLR_H_STOP);
          end
        end
        BCLR_H_STOP: begin
          if (s_r.wait_flag) begin
            s_nxt.cnt = BCLR_HOST_WAIT_CYC;
            s_nxt.st  = BCLR_H_WAIT;
          end else begin
            s_nxt.done = 1'b1;
            s_nxt.st   = BCLR_H_IDLE;
          end
        end
        default: begin
          s_nxt.st = BCLR_H_IDLE;
        end
      endcase
    end else if (s_r.st == BCLR_H_WAIT) begin
      // bus stays idle until the line reset must be over
      if (s_r.cnt == 8'h00) begin
        s_nxt.wait_flag = 1'b0;
        s_nxt = issue(s_nxt, BCLR_K_START, 8'h00, BCLR_H_SR);
      end else begin
        s_nxt.cnt = s_r.cnt - 8'h01;
      end
    end else if (s_r.st == BCLR_H_IDLE && go_i) begin
      s_nxt.op      = op_i;
      s_nxt.arg     = arg_i;
      s_nxt.verify  = verify_i;
      s_nxt.refused = 1'b0;
      s_nxt = issue(s_nxt, BCLR_K_START, 8'h00, BCLR_H_START);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      s_r <= '{st: BCLR_H_IDLE, kind: BCLR_K_STOP, op: BCLR_OP_WRITE_CONFIG_CMD, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// file: bclr_dev.sv
`timescale 1ns/1ps
// Behaviour
// - master writes address, config command, data byte
// - optional repeated-start read confirms written config
// - busy line refuses config command with nak
// - master stops on nak, retries later
// - plain reset: stop, stay idle, then read
// - later read returns status with reset outcome
// - polling reads status until busy clears, nak
// - pointer code E5h is refused with nak
// - pointer code C3h selects configuration register
module bclr_dev (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  bclr_link_if.dev         link,
  input  wire logic        presence_i,
  output logic [7:0]       cfg_o,
  output logic             line_reset_o,
  output logic             line_busy_flag_o
);
  import bclr_pkg::*;

  typedef struct packed {
    bclr_dst_e  st;
    logic       done;
    logic       ack;
    logic [7:0] rdata;
    logic [7:0] cfg;
    logic       ptr_cfg;
    logic       busy;
    logic       presence;
    logic [7:0] cnt;
    logic       rst_pulse;
    logic       pres_meta;
    logic       pres_sync;
  } bclr_dstate_s;

  bclr_dstate_s s_r;
  bclr_dstate_s s_nxt;
  logic [7:0]   status;
  logic [7:0]   rd_byte;
  logic         take;
  logic         addr_hit;
  logic         addr_rd;
  logic         cmd_write_config_cmd;
  logic         cmd_lrst;
  logic         cmd_srp;
  logic         ptr_ok;
  logic         rack_more;
  logic         busy_end;

  assign link.d_done      = s_r.done;
  assign link.d_ack       = s_r.ack;
  assign link.d_data      = s_r.rdata;
  assign cfg_o            = s_r.cfg;
  assign line_reset_o     = s_r.rst_pulse;
  assign line_busy_flag_o = s_r.busy;

  // a request held across its own answer cycle must not be taken twice
  assign take = link.h_valid && !s_r.done;

  // pointer picks the byte; status until a config write or the config pointer code
  always_comb begin
    status                     = 8'h00;
    status[BCLR_STAT_BUSY_BIT] = s_r.busy;
    status[BCLR_STAT_PRES_BIT] = s_r.presence;
    rd_byte                    = s_r.ptr_cfg ? s_r.cfg : status;
  end

  // byte decodes, kept apart so the sequencer reads in transfer order
  always_comb begin
    addr_hit  = (link.h_data[7:1] == BCLR_DEV_ADDR);
    addr_rd   = link.h_data[0];
    cmd_write_config_cmd  = (link.h_data == BCLR_WRITE_CONFIG_CMD);
    cmd_lrst  = (link.h_data == BCLR_LINE_RESET_CMD);
    cmd_srp   = (link.h_data == BCLR_SET_READ_POINTER_CMD);
    ptr_ok    = (link.h_data == BCLR_PTR_CONFIG);
    rack_more = link.h_data[0];
    busy_end  = s_r.busy && (s_r.cnt == 8'h01);
  end

  always_comb begin
    s_nxt           = s_r;
    s_nxt.done      = 1'b0;
    s_nxt.rst_pulse = 1'b0;
    s_nxt.pres_meta = presence_i;
    s_nxt.pres_sync = s_r.pres_meta;

    // line reset timer; outcome caught as the line frees
    if (s_r.busy) begin
      if (busy_end) begin
        s_nxt.busy     = 1'b0;
        s_nxt.presence = s_r.pres_sync;
      end
      s_nxt.cnt = s_r.cnt - 8'h01;
    end

    if (take) begin
      s_nxt.done = 1'b1;
      s_nxt.ack  = 1'b0;
      case (link.h_kind)
        BCLR_K_START: begin
          // start and repeated start both reopen address phase
          s_nxt.ack = 1'b1;
          s_nxt.st  = BCLR_D_ADDR;
        end
        BCLR_K_STOP: begin
          // stop keeps config and pointer for the next transfer
          s_nxt.ack = 1'b1;
          s_nxt.st  = BCLR_D_IDLE;
        end
        BCLR_K_WRITE: begin
          case (s_r.st)
            BCLR_D_ADDR: begin
              if (addr_hit) begin
                s_nxt.ack = 1'b1;
                if (addr_rd) begin
                  s_nxt.st = BCLR_D_READ;
                end else begin
                  s_nxt.st = BCLR_D_CMD;
                end
              end else begin
                // another address: stay silent until the next start
                s_nxt.st = BCLR_D_IGNORE;
              end
            end
            BCLR_D_CMD: begin
              if (cmd_write_config_cmd) begin
                if (s_r.busy) begin
                  // config must not change under a running line reset
                  s_nxt.st = BCLR_D_IGNORE;
                end else begin
                  s_nxt.ack = 1'b1;
                  s_nxt.st  = BCLR_D_CFG;
                end
              end else if (cmd_lrst) begin
                // a reset already running cannot be restarted
                if (s_r.busy) begin
                  s_nxt.st = BCLR_D_IGNORE;
                end else begin
                  s_nxt.ack       = 1'b1;
                  s_nxt.busy      = 1'b1;
                  s_nxt.cnt       = BCLR_LINE_RESET_CYC;
                  s_nxt.rst_pulse = 1'b1;
                  s_nxt.ptr_cfg   = 1'b0;
                  s_nxt.st        = BCLR_D_IGNORE;
                end
              end else if (cmd_srp) begin
                s_nxt.ack = 1'b1;
                s_nxt.st  = BCLR_D_PTR;
              end else begin
                s_nxt.st = BCLR_D_IGNORE;
              end
            end
            BCLR_D_CFG: begin
              s_nxt.ack     = 1'b1;
              s_nxt.cfg     = link.h_data;
              // one data byte only; later writes are refused
              s_nxt.ptr_cfg = 1'b1;
              s_nxt.st      = BCLR_D_IGNORE;
            end
            BCLR_D_PTR: begin
              if (ptr_ok) begin
                s_nxt.ack     = 1'b1;
                s_nxt.ptr_cfg = 1'b1;
              end
              // every other code, the invalid one among them, gets a nak
              s_nxt.st = BCLR_D_IGNORE;
            end
            default: begin
              s_nxt.st = BCLR_D_IGNORE;
            end
          endcase
        end
        BCLR_K_READ: begin
          if (s_r.st == BCLR_D_READ) begin
            s_nxt.ack   = 1'b1;
            s_nxt.rdata = rd_byte;
          end else begin
            // not addressed for read: a released bus reads all ones
            s_nxt.rdata = BCLR_IDLE_READ;
          end
        end
        BCLR_K_RACK: begin
          s_nxt.ack = 1'b1;
          // master nak ends the read; an ack asks for one more byte
          if (s_r.st == BCLR_D_READ && !rack_more) begin
            s_nxt.st = BCLR_D_IGNORE;
          end
        end
        default: begin
          s_nxt.st = BCLR_D_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      s_r <= '{
        st:      BCLR_D_IDLE,
        cfg:     BCLR_CFG_RESET,
        default: '0
      };
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// file: bclr_link_props.sv
`timescale 1ns/1ps
module bclr_link_props (
  input wire logic                sys_clk_i,
  input wire logic                rstn_i,
  input wire logic                h_valid,
  input wire bclr_pkg::bclr_kind_e h_kind,
  input wire logic [7:0]          h_data,
  input wire logic                d_done,
  input wire logic                d_ack,
  input wire logic [7:0]          d_data
);
  import bclr_pkg::*;
  logic [1:0] idx_r;
  logic       rw_r;
  logic [7:0] cmd_r;
  logic [7:0] wd_r;

  // byte position within a transfer; command cleared on stop so later reads are unbound
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      idx_r <= 2'h0;
      rw_r  <= 1'b0;
      cmd_r <= 8'h00;
      wd_r  <= 8'h00;
    end else if (d_done) begin
      if (h_kind == BCLR_K_START) idx_r <= 2'h0;
      if (h_kind == BCLR_K_STOP) begin
        idx_r <= 2'h0;
        cmd_r <= 8'h00;
      end
      if (h_kind == BCLR_K_WRITE) begin
        if (idx_r != 2'h3) idx_r <= idx_r + 2'h1;
        if (idx_r == 2'h0) rw_r <= h_data[0];
        if (idx_r == 2'h1 && !rw_r) cmd_r <= h_data;
        if (idx_r == 2'h2 && cmd_r == BCLR_WRITE_CONFIG_CMD && d_ack) wd_r <= h_data;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  a_take_answer: assert property (h_valid && !d_done |=> d_done)
    else $error("request not answered next cycle");
  a_done_cause: assert property (d_done |-> $past(h_valid) && !$past(d_done))
    else $error("answer without a taken request");
  a_req_stable: assert property (h_valid && !d_done |=> h_valid && $stable(h_kind) && $stable(h_data))
    else $error("request changed before answer");
  a_addr_ack: assert property (d_done && h_kind == BCLR_K_WRITE && idx_r == 2'h0 |->
    d_ack == (h_data[7:1] == BCLR_DEV_ADDR)) else $error("address ack wrong");
  a_stop_after_nak: assert property (d_done && !d_ack && h_kind == BCLR_K_WRITE |=>
    h_valid && h_kind == BCLR_K_STOP) else $error("no stop after nak");
  a_read_then_rack: assert property (d_done && h_kind == BCLR_K_READ |=>
    h_valid && h_kind == BCLR_K_RACK) else $error("read not followed by ack bit");
  a_bad_ptr_nak: assert property (d_done && h_kind == BCLR_K_WRITE && idx_r == 2'h2 &&
    cmd_r == BCLR_SET_READ_POINTER_CMD && h_data == BCLR_PTR_INVALID |-> !d_ack)
    else $error("invalid pointer acked");
  a_good_ptr_ack: assert property (d_done && h_kind == BCLR_K_WRITE && idx_r == 2'h2 &&
    cmd_r == BCLR_SET_READ_POINTER_CMD && h_data == BCLR_PTR_CONFIG |-> d_ack)
    else $error("config pointer refused");
  a_poll_ack: assert property (h_valid && h_kind == BCLR_K_RACK && cmd_r == BCLR_LINE_RESET_CMD |->
    h_data[0] == d_data[BCLR_STAT_BUSY_BIT]) else $error("poll ack does not follow busy bit");
  a_readback: assert property (d_done && h_kind == BCLR_K_READ && cmd_r == BCLR_WRITE_CONFIG_CMD |->
    d_data == wd_r) else $error("readback differs from written config");
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import bclr_pkg::*;
  typedef struct packed {
    bclr_op_e   op;
    logic [7:0] arg;
    logic       ver;
    logic       pres;
    logic       refd;
    logic       chk;
    logic [7:0] rd;
    logic [7:0] cfg;
  } bclr_row_s;
  localparam bclr_row_s ROWS [0:7] = '{
    '{BCLR_OP_WRITE_CONFIG_CMD,       8'h5A, 1'b1, 1'b0, 1'b0, 1'b1, 8'h5A, 8'h5A},
    '{BCLR_OP_WRITE_CONFIG_CMD,       8'hA5, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'hA5},
    '{BCLR_OP_SETPTR,     8'hC3, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'hA5},
    '{BCLR_OP_SETPTR,     8'hE5, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'hA5},
    '{BCLR_OP_LRST_POLL,  8'h00, 1'b0, 1'b1, 1'b0, 1'b1, 8'h02, 8'hA5},
    '{BCLR_OP_LRST_PLAIN, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'hA5},
    '{BCLR_OP_LRST_PLAIN, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1, 8'h02, 8'hA5},
    '{BCLR_OP_WRITE_CONFIG_CMD,       8'h00, 1'b1, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00}
  };
  localparam logic [1:0] ACK = 2'h3;
  localparam logic [1:0] NAK = 2'h2;
  localparam logic [1:0] ANY = 2'h0;
  localparam logic [7:0] ADW = {BCLR_DEV_ADDR, 1'b0};

  logic       sys_clk_i;
  logic       rstn_i;
  logic       go_i;
  bclr_op_e   op_i;
  logic [7:0] arg_i;
  logic       verify_i;
  logic       presence_i;
  logic       done_o;
  logic       refused_o;
  logic [7:0] rd_data_o;
  logic       busy_o;
  logic [7:0] cfg_o;
  logic       line_busy_flag_o;
  logic [7:0] cfg_b;
  logic       busy_b;
  logic       lrst_a;
  logic       lrst_b;
  int         rst_pulses;
  int         miscompares;
  int         num_checks;

  bclr_link_if i_bclr_link_if ();
  bclr_link_if i_bclr_link_if_b ();
  bclr_host i_bclr_host (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .link(i_bclr_link_if), .go_i(go_i),
    .op_i(op_i), .arg_i(arg_i), .verify_i(verify_i), .done_o(done_o), .refused_o(refused_o),
    .rd_data_o(rd_data_o), .busy_o(busy_o));
  bclr_dev i_bclr_dev (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .link(i_bclr_link_if),
    .presence_i(presence_i), .cfg_o(cfg_o), .line_reset_o(lrst_a), .line_busy_flag_o(line_busy_flag_o));
  // second device driven by hand so a command can arrive while the line is busy
  bclr_dev i_bclr_dev_b (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .link(i_bclr_link_if_b),
    .presence_i(1'b1), .cfg_o(cfg_b), .line_reset_o(lrst_b), .line_busy_flag_o(busy_b));
  bclr_link_props i_bclr_link_props (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .h_valid(i_bclr_link_if.h_valid), .h_kind(i_bclr_link_if.h_kind), .h_data(i_bclr_link_if.h_data),
    .d_done(i_bclr_link_if.d_done), .d_ack(i_bclr_link_if.d_ack), .d_data(i_bclr_link_if.d_data));

  always #10 sys_clk_i = ~sys_clk_i;

  // line reset start pulses of both devices, one per accepted command
  always @(posedge sys_clk_i) begin
    rst_pulses <= rst_pulses + int'(lrst_a === 1'b1) + int'(lrst_b === 1'b1);
  end

  task automatic summarize();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (s !== v) begin
      miscompares++;
      $display("Error at %0t: wait timed out", $time);
      summarize();
    end
  endtask

  // request held from a falling edge until the answer edge has passed
  task automatic tx(input bclr_kind_e k, input logic [7:0] d, input logic [1:0] a);
    logic ak;
    @(negedge sys_clk_i);
    i_bclr_link_if_b.h_valid = 1'b1;
    i_bclr_link_if_b.h_kind = k;
    i_bclr_link_if_b.h_data = d;
    @(negedge sys_clk_i);
    wait_lvl(i_bclr_link_if_b.d_done, 1'b1, 20);
    ak = i_bclr_link_if_b.d_ack;
    @(posedge sys_clk_i);
    if (a[1]) chk({7'h00, ak}, {7'h00, a[0]}, "device ack");
    @(negedge sys_clk_i);
    i_bclr_link_if_b.h_valid = 1'b0;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    rstn_i = 1'b0;
    go_i = 1'b0;
    op_i = BCLR_OP_WRITE_CONFIG_CMD;
    arg_i = 8'h00;
    verify_i = 1'b0;
    presence_i = 1'b0;
    i_bclr_link_if_b.h_valid = 1'b0;
    i_bclr_link_if_b.h_kind = BCLR_K_START;
    i_bclr_link_if_b.h_data = 8'h00;
    miscompares = 0;
    num_checks = 0;
    rst_pulses = 0;
    repeat (20) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    @(negedge sys_clk_i);
    chk(cfg_o, BCLR_CFG_RESET, "config after reset");
    chk({5'h00, done_o, busy_o, line_busy_flag_o}, 8'h00, "outputs after reset");
    foreach (ROWS[i]) begin
      presence_i = ROWS[i].pres;
      op_i = ROWS[i].op;
      arg_i = ROWS[i].arg;
      verify_i = ROWS[i].ver;
      go_i = 1'b1;
      @(negedge sys_clk_i);
      go_i = 1'b0;
      wait_lvl(done_o, 1'b1, 1000);
      chk({7'h00, refused_o}, {7'h00, ROWS[i].refd}, "refused");
      if (ROWS[i].chk) chk(rd_data_o, ROWS[i].rd, "read byte");
      chk({7'h00, line_busy_flag_o}, 8'h00, "line busy at end");
      chk(cfg_o, ROWS[i].cfg, "config");
      @(negedge sys_clk_i);
    end
    chk(8'(rst_pulses), 8'h03, "line reset pulses");
    tx(BCLR_K_START, 8'h00, ANY);
    tx(BCLR_K_WRITE, ADW, ACK);
    tx(BCLR_K_WRITE, BCLR_LINE_RESET_CMD, ACK);
    tx(BCLR_K_STOP, 8'h00, ANY);
    chk({7'h00, busy_b}, 8'h01, "line busy after reset command");
    chk(8'(rst_pulses), 8'h04, "line reset pulses, both devices");
    tx(BCLR_K_START, 8'h00, ANY);
    tx(BCLR_K_WRITE, ADW, ACK);
    tx(BCLR_K_WRITE, BCLR_WRITE_CONFIG_CMD, NAK);
    tx(BCLR_K_STOP, 8'h00, ANY);
    wait_lvl(busy_b, 1'b0, 200);
    tx(BCLR_K_START, 8'h00, ANY);
    tx(BCLR_K_WRITE, ADW ^ 8'h02, NAK);
    tx(BCLR_K_STOP, 8'h00, ANY);
    tx(BCLR_K_START, 8'h00, ANY);
    tx(BCLR_K_WRITE, ADW, ACK);
    tx(BCLR_K_WRITE, BCLR_WRITE_CONFIG_CMD, ACK);
    tx(BCLR_K_WRITE, 8'h3C, ACK);
    tx(BCLR_K_WRITE, 8'h11, NAK);
    tx(BCLR_K_STOP, 8'h00, ANY);
    chk(cfg_b, 8'h3C, "config after retry");
    rstn_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    @(negedge sys_clk_i);
    chk(cfg_o, BCLR_CFG_RESET, "config after second reset");
    chk(cfg_b, BCLR_CFG_RESET, "second device config after reset");
    chk({6'h00, busy_b, line_busy_flag_o}, 8'h00, "line busy after second reset");
    op_i = BCLR_OP_WRITE_CONFIG_CMD;
    arg_i = 8'h66;
    verify_i = 1'b1;
    go_i = 1'b1;
    @(negedge sys_clk_i);
    go_i = 1'b0;
    wait_lvl(done_o, 1'b1, 1000);
    chk(rd_data_o, 8'h66, "readback after second reset");
    chk(cfg_o, 8'h66, "config after second reset write");
    summarize();
  end
endmodule
